// file: hw/oopc_top.sv
// oopc_top: on/off power controller with an APB register slave
// assumes line, buttons and supply inputs are already clean and synchronous to clk
// Function
// - control line rising starts device when enabled
// - line start enabled at reset, software clears
// - act on low only after response time
// - sustained low shuts down, or suspends, or nothing
// - no restart without fresh rise after shutdown
// - start button short press starts; none at reset
// - action button short/long press shuts down
// - press is long after long-press timeout
// - always-on starts when supply appears; off at reset
// - always-on keeps suspend, shutdown, restart paths
// - shutdown triggers ignored while suspended
// - suspend timeout shuts down; zero disables
// - action button held forces immediate power-off
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "oopc_cfg.svh"

module oopc_top #(
	parameter int CYC_PER_MS = `OOPC_MS_NS / `OOPC_CLK_NS
) (
	// clock and power-on reset
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// field inputs
	input  wire logic                   line_high,
	input  wire logic [`OOPC_NBTN-1:0]  btn_pressed,
	input  wire logic                   supply_present,
	input  wire logic                   host_halted,
	// power outputs
	output logic                        power_en,
	output logic                        shutdown_req,
	output logic                        suspend_req,
	output oopc_pkg::oopc_state_type    state
);
	import oopc_pkg::*;

	// is this byte offset a mapped register
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == `OOPC_ADDR_CTRL) || (a == `OOPC_ADDR_RESP) ||
			(a == `OOPC_ADDR_LONG) || (a == `OOPC_ADDR_SUSP) || (a == `OOPC_ADDR_STATUS);
	endfunction

	logic [15:0]            ctrl;
	logic [15:0]            resp_ms;
	logic [15:0]            long_ms;
	logic [15:0]            susp_min;
	logic [15:0]            next_ctrl;
	logic [15:0]            next_resp_ms;
	logic [15:0]            next_long_ms;
	logic [15:0]            next_susp_min;
	logic [31:0]            next_prdata;
	logic                   next_pready;
	logic                   next_pslverr;
	logic                   wr_go;

	// apb: one wait state so read data and pready both come from flops
	assign wr_go = psel && penable && pready && pwrite;
	always_comb begin
		next_ctrl     = ctrl;
		next_resp_ms  = resp_ms;
		next_long_ms  = long_ms;
		next_susp_min = susp_min;
		next_pready   = psel && penable && !pready;
		next_prdata   = prdata;
		next_pslverr  = 1'b0;
		if (psel && penable && !pready) begin
			next_pslverr = !addr_mapped(paddr);
			case (paddr)
				`OOPC_ADDR_CTRL:   next_prdata = {16'h0000, ctrl};
				`OOPC_ADDR_RESP:   next_prdata = {16'h0000, resp_ms};
				`OOPC_ADDR_LONG:   next_prdata = {16'h0000, long_ms};
				`OOPC_ADDR_SUSP:   next_prdata = {16'h0000, susp_min};
				`OOPC_ADDR_STATUS: next_prdata = {23'h000000, btn_pressed, line_high, state};
				default:           next_prdata = 32'h00000000;
			endcase
		end
		if (wr_go) begin
			case (paddr)
				`OOPC_ADDR_CTRL: next_ctrl     = pwdata[15:0];
				`OOPC_ADDR_RESP: next_resp_ms  = pwdata[15:0];
				`OOPC_ADDR_LONG: next_long_ms  = pwdata[15:0];
				`OOPC_ADDR_SUSP: next_susp_min = pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl     <= `OOPC_CTRL_RST;
			resp_ms  <= `OOPC_RESP_RST;
			long_ms  <= `OOPC_LONG_RST;
			susp_min <= `OOPC_SUSP_RST;
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else begin
			ctrl     <= next_ctrl;
			resp_ms  <= next_resp_ms;
			long_ms  <= next_long_ms;
			susp_min <= next_susp_min;
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
		end
	end

	// millisecond and second ticks; line and button timing works in ms, the suspend timer in seconds, to keep counters small
	logic [16:0]            ms_pre;
	logic [16:0]            next_ms_pre;
	logic [9:0]             sec_pre;
	logic [9:0]             next_sec_pre;
	logic                   ms_tick;
	logic                   sec_tick;
	assign ms_tick  = (ms_pre == 17'(CYC_PER_MS - 1));
	assign sec_tick = ms_tick && (sec_pre == `OOPC_SEC_MS - 10'h001);
	always_comb begin
		next_ms_pre  = ms_tick ? 17'h00000 : ms_pre + 17'h00001;
		next_sec_pre = sec_pre;
		if (ms_tick) begin
			next_sec_pre = sec_tick ? 10'h000 : sec_pre + 10'h001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ms_pre  <= 17'h00000;
			sec_pre <= 10'h000;
		end else begin
			ms_pre  <= next_ms_pre;
			sec_pre <= next_sec_pre;
		end
	end

	// control line low timer and edge memory
	logic [16:0]            low_cnt;
	logic [16:0]            next_low_cnt;
	logic                   low_done;
	logic                   next_low_done;
	logic                   line_prev;
	logic                   supply_prev;
	logic                   low_evt;
	logic                   line_rise;
	logic                   supply_rise;
	// strictly greater: the free-running ms tick may land just after the line
	// falls, so reaching the count alone can be up to one ms short
	assign low_evt     = !line_high && (low_cnt > {1'b0, resp_ms}) && !low_done;
	assign line_rise   = line_high && !line_prev;
	assign supply_rise = supply_present && !supply_prev;
	always_comb begin
		next_low_cnt  = low_cnt;
		next_low_done = low_done | low_evt;
		if (line_high) begin
			next_low_cnt  = 17'h00000;
			next_low_done = 1'b0;
		end else if (ms_tick && low_cnt != 17'h1ffff) begin
			next_low_cnt = low_cnt + 17'h00001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt     <= 17'h00000;
			low_done    <= 1'b0;
			line_prev   <= 1'b0;
			supply_prev <= 1'b0;
		end else begin
			low_cnt     <= next_low_cnt;
			low_done    <= next_low_done;
			line_prev   <= line_high;
			supply_prev <= supply_present;
		end
	end

	// button hold timers: release before the long timeout is a short press
	logic [`OOPC_NBTN-1:0]  short_evt;
	logic [`OOPC_NBTN-1:0]  long_evt;
	logic [`OOPC_NBTN-1:0]  force_hit;
	logic [16:0]            force_ms;
	assign force_ms = ({1'b0, long_ms} << 1) > `OOPC_FORCE_MIN_MS ?
		({1'b0, long_ms} << 1) : `OOPC_FORCE_MIN_MS;

	genvar gi;
	generate
		for (gi = 0; gi < `OOPC_NBTN; gi++) begin : g_btn
			logic [16:0] hold;
			logic [16:0] next_hold;
			logic        long_seen;
			logic        next_long_seen;
			logic        prev;
			assign short_evt[gi] = !btn_pressed[gi] && prev && !long_seen;
			// strictly greater for the same ms tick phase reason as the line timer
			assign long_evt[gi]  = btn_pressed[gi] && (hold > {1'b0, long_ms}) && !long_seen;
			assign force_hit[gi] = btn_pressed[gi] && (hold > force_ms);
			always_comb begin
				next_hold      = hold;
				next_long_seen = long_seen | long_evt[gi];
				if (!btn_pressed[gi]) begin
					next_hold      = 17'h00000;
					next_long_seen = 1'b0;
				end else if (ms_tick && hold != 17'h1ffff) begin
					next_hold = hold + 17'h00001;
				end
			end
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					hold      <= 17'h00000;
					long_seen <= 1'b0;
					prev      <= 1'b0;
				end else begin
					hold      <= next_hold;
					long_seen <= next_long_seen;
					prev      <= btn_pressed[gi];
				end
			end
		end
	endgenerate

	// trigger decoding
	logic                   start_trig;
	logic                   shdn_trig;
	logic                   susp_trig;
	logic                   force_off;
	logic                   start_btn;
	logic [`OOPC_NBTN-1:0]  act_mask;
	logic [21:0]            susp_sec;
	logic [21:0]            next_susp_sec;
	logic [21:0]            susp_limit;
	assign act_mask   = ctrl[`OOPC_F_BACT];
	assign start_btn  = |(short_evt & ctrl[`OOPC_F_BSTART]);
	assign force_off  = |(force_hit & act_mask);
	assign start_trig = (ctrl[`OOPC_F_LSTART] && line_rise) || start_btn;
	assign shdn_trig  = (low_evt && ctrl[`OOPC_F_LACT] == OOPC_ACT_SHDN) ||
		(|(short_evt & act_mask) && ctrl[`OOPC_F_SACT] == OOPC_ACT_SHDN) ||
		(|(long_evt & act_mask) && ctrl[`OOPC_F_LGACT] == OOPC_ACT_SHDN);
	assign susp_trig  = (low_evt && ctrl[`OOPC_F_LACT] == OOPC_ACT_SUSP) ||
		(|(short_evt & act_mask) && ctrl[`OOPC_F_SACT] == OOPC_ACT_SUSP) ||
		(|(long_evt & act_mask) && ctrl[`OOPC_F_LGACT] == OOPC_ACT_SUSP);
	assign susp_limit = 22'(susp_min) * `OOPC_MIN_SEC;

	// power state machine
	oopc_state_type         next_state;
	always_comb begin
		next_state    = state;
		next_susp_sec = susp_sec;
		case (state)
			OOPC_OFF: begin
				// line edge memory keeps running through shutdown, so a rise
				// that came during shutdown is already consumed here
				if (start_trig || (ctrl[`OOPC_F_AON] && supply_rise)) begin
					next_state = OOPC_RUN;
				end
			end
			OOPC_RUN: begin
				if (shdn_trig) begin
					next_state = OOPC_SHDN;
				end else if (susp_trig) begin
					next_state    = OOPC_SUSP;
					next_susp_sec = 22'h000000;
				end
			end
			OOPC_SUSP: begin
				// shutdown triggers are not looked at here
				if (sec_tick) begin
					next_susp_sec = susp_sec + 22'h000001;
				end
				if (start_trig) begin
					next_state = OOPC_RUN;
				end else if (susp_min != 16'h0000 && susp_sec > susp_limit) begin
					next_state = OOPC_SHDN;
				end
			end
			OOPC_SHDN: begin
				if (host_halted) begin
					next_state = OOPC_OFF;
				end
			end
			default: next_state = OOPC_OFF;
		endcase
		if (force_off) begin
			next_state = OOPC_OFF;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state        <= OOPC_OFF;
			susp_sec     <= 22'h000000;
			power_en     <= 1'b0;
			shutdown_req <= 1'b0;
			suspend_req  <= 1'b0;
		end else begin
			state        <= next_state;
			susp_sec     <= next_susp_sec;
			power_en     <= (next_state != OOPC_OFF);
			shutdown_req <= (next_state == OOPC_SHDN);
			suspend_req  <= (next_state == OOPC_SUSP);
		end
	end
endmodule

// file: hw/oopc_cfg.svh
// oopc_cfg.svh: offsets, field positions, reset values and timing for the power controller
// assumes the includer also imports oopc_pkg for the matching types
`ifndef OOPC_CFG_SVH
`define OOPC_CFG_SVH

// timing
`define OOPC_CLK_NS        10
`define OOPC_MS_NS         1000000
`define OOPC_SEC_MS        10'h3e8
`define OOPC_MIN_SEC       22'h00003c
`define OOPC_FORCE_MIN_MS  17'h01f40
`define OOPC_NBTN          4

// register byte offsets
`define OOPC_ADDR_CTRL     8'h00
`define OOPC_ADDR_RESP     8'h04
`define OOPC_ADDR_LONG     8'h08
`define OOPC_ADDR_SUSP     8'h0c
`define OOPC_ADDR_STATUS   8'h10

// control fields
`define OOPC_F_LSTART      0
`define OOPC_F_LACT        2:1
`define OOPC_F_AON         3
`define OOPC_F_BSTART      7:4
`define OOPC_F_BACT        11:8
`define OOPC_F_SACT        13:12
`define OOPC_F_LGACT       15:14

// reset values
`define OOPC_CTRL_RST      16'h0003
`define OOPC_RESP_RST      16'h0fa0
`define OOPC_LONG_RST      16'h0fa0
`define OOPC_SUSP_RST      16'h003c

`endif

// file: hw/oopc_pkg.sv
// oopc_pkg: types shared by the on/off power controller
// assumes nothing beyond a SystemVerilog compiler
package oopc_pkg;
	// one-hot power states
	typedef enum logic [3:0] {
		OOPC_OFF  = 4'h1,
		OOPC_RUN  = 4'h2,
		OOPC_SUSP = 4'h4,
		OOPC_SHDN = 4'h8
	} oopc_state_type;

	// action assigned to a trigger
	typedef enum logic [1:0] {
		OOPC_ACT_NONE = 2'h0,
		OOPC_ACT_SHDN = 2'h1,
		OOPC_ACT_SUSP = 2'h2
	} oopc_act_type;
endpackage

// file: tb/oopc_chk.sv
// oopc_chk: port-level assertions for the power controller
// assumes it is bound to oopc_top and sees only that module's ports
`timescale 1ns/100ps
module oopc_chk (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  resetn,
	// apb side
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// field side
	input wire logic                  line_high,
	input wire logic [3:0]            btn_pressed,
	input wire logic                  supply_present,
	input wire logic                  host_halted,
	input wire logic                  power_en,
	input wire logic                  shutdown_req,
	input wire logic                  suspend_req,
	input wire oopc_pkg::oopc_state_type state
);
	import oopc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// outputs are levels tied to the state
	a_power_level: assert property (power_en == (state != OOPC_OFF)) else $error("power level");
	a_shdn_level: assert property (shutdown_req == (state == OOPC_SHDN)) else $error("shdn level");
	a_susp_level: assert property (suspend_req == (state == OOPC_SUSP)) else $error("susp level");
	// one wait state, answer lasts one cycle
	a_pready_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready");
	a_pready_once: assert property (pready |=> !pready) else $error("ready held");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
	// host halt finishes the shutdown at once
	a_shdn_exit: assert property (state == OOPC_SHDN && host_halted |=> state == OOPC_OFF)
		else $error("shdn stuck");
	// a line already high through shutdown is no fresh rise
	a_no_restart: assert property ((state == OOPC_SHDN && line_high && btn_pressed == 4'h0)
		##1 (state == OOPC_OFF && line_high && btn_pressed == 4'h0 && $stable(supply_present))
		|=> state == OOPC_OFF)
		else $error("restart");
	// no trigger at all, so no start; latency of two edges allowed for
	a_no_wake: assert property (state == OOPC_OFF && !line_high && btn_pressed == 4'h0 &&
		$past(btn_pressed) == 4'h0 && $stable(supply_present) |=> state == OOPC_OFF)
		else $error("spurious start");
	c_susp: cover property (state == OOPC_SUSP);
	c_halt: cover property (state == OOPC_SHDN ##1 state == OOPC_OFF);
	c_err: cover property (pslverr);
endmodule

bind oopc_top oopc_chk u_oopc_chk (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .line_high(line_high), .btn_pressed(btn_pressed),
	.supply_present(supply_present), .host_halted(host_halted), .power_en(power_en),
	.shutdown_req(shutdown_req), .suspend_req(suspend_req), .state(state));

// file: tb/oopc_host.sv
// oopc_host: host side that finishes a shutdown some cycles after it is asked
// assumes one clock shared with the controller
`timescale 1ns/100ps
module oopc_host #(
	parameter int DLY = 8
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic shutdown_req,
	output logic      host_halted
);
	int cnt;
	// halted only after the request stood DLY cycles, never early
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
		end else begin
			cnt <= shutdown_req ? cnt + 1 : 0;
		end
	end
	assign host_halted = shutdown_req && (cnt >= DLY);
endmodule

// file: tb/tb_on_off_power_control.sv
// tb_on_off_power_control: register, line, button and always-on checks
// assumes oopc_top with a one-clock ms tick and the host model as far side
`timescale 1ns/100ps
`include "oopc_cfg.svh"
module tb_on_off_power_control;
	import oopc_pkg::*;
	logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, line_high = 0, supply_present = 1, host_halted;
	logic [3:0] btn_pressed = 4'h0;
	logic power_en, shutdown_req, suspend_req;
	oopc_state_type state;
	int err_total = 0, total_checks = 0, cyc = 0;
	// reset rows: address, value, error flag
	logic [40:0] rows [6] = '{{8'h00, 32'h3, 1'b0}, {8'h04, 32'hfa0, 1'b0},
		{8'h08, 32'hfa0, 1'b0}, {8'h0c, 32'h3c, 1'b0}, {8'h10, 32'h1, 1'b0},
		{8'h14, 32'h0, 1'b1}};
	oopc_top #(.CYC_PER_MS(1)) u_oopc_top (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_high(line_high), .btn_pressed(btn_pressed),
		.supply_present(supply_present), .host_halted(host_halted), .power_en(power_en),
		.shutdown_req(shutdown_req), .suspend_req(suspend_req), .state(state));
	oopc_host u_oopc_host (.clk(clk), .resetn(resetn), .shutdown_req(shutdown_req),
		.host_halted(host_halted));
	initial begin
		forever #5 clk = ~clk;
	end
	// a hang ends the run as a failure; the one-minute suspend test alone needs ~61000
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// setup, access, then hold until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_st(input oopc_state_type s, input int n);
		do @(posedge clk); while (state !== s && --n > 0);
		chk(state, s);
	endtask
	task automatic press(input int n);
		@(posedge clk) btn_pressed <= 4'h1;
		cy(n);
		btn_pressed <= 4'h0;
	endtask
	initial begin
		cy(5);
		resetn <= 1'b1;
		chk(state, OOPC_OFF);
		foreach (rows[i]) begin
			apb(1'b0, rows[i][40:33], 32'h0);
			chk(rd, rows[i][32:1]);
			chk(er, rows[i][0]);
		end
		apb(1'b1, `OOPC_ADDR_RESP, 32'h1e);
		apb(1'b1, `OOPC_ADDR_LONG, 32'h14);
		line_high <= 1'b1;
		wait_st(OOPC_RUN, 5);
		// short lows restart the low timer each time
		repeat (2) begin
			line_high <= 1'b0;
			cy(15);
			line_high <= 1'b1;
			cy(1);
		end
		chk(state, OOPC_RUN);
		line_high <= 1'b0;
		cy(15);
		chk(state, OOPC_RUN);
		wait_st(OOPC_SHDN, 40);
		line_high <= 1'b1;
		wait_st(OOPC_OFF, 20);
		cy(20);
		chk(state, OOPC_OFF);
		line_high <= 1'b0;
		cy(2);
		line_high <= 1'b1;
		wait_st(OOPC_RUN, 5);
		// line low now suspends; button shutdown must be ignored in suspend
		apb(1'b1, `OOPC_ADDR_CTRL, 32'h1105);
		line_high <= 1'b0;
		wait_st(OOPC_SUSP, 40);
		press(5);
		cy(10);
		chk(state, OOPC_SUSP);
		line_high <= 1'b1;
		wait_st(OOPC_RUN, 5);
		// button start and short-press shutdown, line start off
		apb(1'b1, `OOPC_ADDR_CTRL, 32'h1110);
		press(5);
		wait_st(OOPC_SHDN, 5);
		wait_st(OOPC_OFF, 20);
		line_high <= 1'b0;
		cy(2);
		line_high <= 1'b1;
		cy(5);
		chk(state, OOPC_OFF);
		press(5);
		wait_st(OOPC_RUN, 5);
		// line low with no action assigned leaves the device running
		line_high <= 1'b0;
		cy(40);
		chk(state, OOPC_RUN);
		line_high <= 1'b1;
		// long press only
		apb(1'b1, `OOPC_ADDR_CTRL, 32'h4110);
		@(posedge clk) btn_pressed <= 4'h1;
		cy(8);
		chk(state, OOPC_RUN);
		wait_st(OOPC_SHDN, 30);
		btn_pressed <= 4'h0;
		wait_st(OOPC_OFF, 20);
		// always-on starts on supply arrival
		apb(1'b1, `OOPC_ADDR_CTRL, 32'h8);
		supply_present <= 1'b0;
		cy(3);
		supply_present <= 1'b1;
		wait_st(OOPC_RUN, 5);
		// action button held past the forced-off time, every press action none
		apb(1'b1, `OOPC_ADDR_CTRL, 32'h100);
		@(posedge clk) btn_pressed <= 4'h1;
		cy(7990);
		chk(state, OOPC_RUN);
		wait_st(OOPC_OFF, 30);
		btn_pressed <= 4'h0;
		// one-minute suspend timeout ends in shutdown
		apb(1'b1, `OOPC_ADDR_SUSP, 32'h1);
		apb(1'b1, `OOPC_ADDR_CTRL, 32'h5);
		line_high <= 1'b0;
		cy(2);
		line_high <= 1'b1;
		wait_st(OOPC_RUN, 5);
		line_high <= 1'b0;
		wait_st(OOPC_SUSP, 40);
		cy(58000);
		chk(state, OOPC_SUSP);
		wait_st(OOPC_SHDN, 4000);
		wait_st(OOPC_OFF, 20);
		end_sim();
	end
endmodule
